//--- rtl/asp_top.sv
// Notes on behaviour
// RQ1: Serial function only on controller one with mode written to 1.
// RQ2: Bit rate is 24 MHz over twice integer divisor plus fraction.
// RQ3: Software keeps the integer divisor at 8 or more.
// RQ4: Transmit one or two stop bits; receive needs only one.
// RQ5: Parity enable adds a parity bit in both directions.
// RQ6: Parity is XOR of data, inverted when odd; ignored if disabled.
// RQ7: Frame is start, 7 or 8 data LSB first, parity, stop.
// RQ8: Idle line is high; every character opens with a low start.
// RQ9: Four-entry FIFOs; data write pushes transmit, read pops receive.
// RQ10: DMA channels use the same FIFOs as the data port.
// RQ11: With flow control, start characters only while clear-to-send low.
// RQ12: Automatic request low while receive FIFO has two free entries.
// RQ13: Manual request follows the software request bit.
// RQ14: Flow control off ignores clear-to-send and leaves request idle.
// RQ15: DMA pop of flagged character records first error offset.
// RQ16: Overrun flags at once; offset recorded four characters ahead.
// RQ17: Error record clears on DMA reset or reload after unload.
// RQ18: Transmit idle event, edge or level per mode bit.
// RQ19: Transmit space event on full to not full, edge or level.
// RQ20: Receive data event on empty to not empty, edge or level.
// RQ21: Buffer complete event when a buffer active flag falls.
// RQ22: Separate parity, framing and overrun events.
// RQ23: Mode field: 0 off, 1 serial, 2 SPI, 3 I2C.
// RQ24: Start bit must stay low to mid-bit, else false start.
`timescale 1ns/1ns
`default_nettype none
module asp_top #(
  parameter int unsigned CTRL_ID = asp_pkg::CTRL_ID_DEF,
  parameter int unsigned DEPTH = asp_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [1:0] controller_mode_select_i,
  input wire logic [asp_pkg::DIVN_W-1:0] baud_integer_divisor_i,
  input wire logic [asp_pkg::DIVF_W-1:0] baud_fraction_divisor_i,
  input wire asp_pkg::asp_cfg_t char_format_config_i,
  input wire logic event_edge_level_select_i,
  input wire logic data_wr_i,
  input wire logic [7:0] data_wdata_i,
  input wire logic data_rd_i,
  input wire logic dma_tx_wr_i,
  input wire logic [7:0] dma_tx_wdata_i,
  input wire logic dma_rx_rd_i,
  input wire logic rx_dma_reset_i,
  input wire logic rx_dma_buf_sel_i,
  input wire logic [asp_pkg::OFF_W-1:0] rx_dma_count_i,
  input wire logic [1:0] rx_buffer_load_ab_i,
  input wire logic [1:0] tx_buffer_active_ab_i,
  input wire logic [1:0] rx_buffer_active_ab_i,
  input wire logic rxd_i,
  input wire logic ncts_i,
  output logic txd_o,
  output logic nrts_o,
  output asp_pkg::asp_rx_char_t rx_char_o,
  output logic tx_idle_flag_o,
  output logic tx_space_flag_o,
  output logic rx_valid_flag_o,
  output logic ev_tx_idle_o,
  output logic ev_tx_space_o,
  output logic ev_rx_valid_o,
  output logic [1:0] ev_tx_done_ab_o,
  output logic [1:0] ev_rx_done_ab_o,
  output logic ev_parity_err_o,
  output logic ev_frame_err_o,
  output logic rx_overrun_event_o,
  output logic [asp_pkg::OFF_W-1:0] rx_error_offset_a_o,
  output logic [asp_pkg::OFF_W-1:0] rx_error_offset_b_o,
  output logic [1:0] rx_error_valid_ab_o
);
  import asp_pkg::*;

  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam int unsigned BW = DIVN_W + 2;

  if (DEPTH < RTS_MIN_FREE) begin : g_chk
    $error("asp_top: receive FIFO shallower than request threshold");
  end

  // ********************************
  // Mode decode and reference tick
  // ********************************
  asp_cfg_t cfg;
  logic uart_en, ref_tick;
  logic [7:0] acc_q, acc_d, acc_sum;
  logic [BW-1:0] divisor;

  assign cfg = char_format_config_i;
  assign uart_en = (controller_mode_select_i == MODE_UART) &&
                   (CTRL_ID == 1); // [RQ1] [RQ23]
  assign acc_sum = acc_q + REF_MHZ;
  assign ref_tick = (acc_sum >= CLK_MHZ);
  assign divisor = {1'b0, baud_integer_divisor_i, 1'b0} +
                   BW'(baud_fraction_divisor_i); // [RQ2] [RQ3]

  always_comb begin
    acc_d = ref_tick ? acc_sum - CLK_MHZ : acc_sum; // [RQ2]
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_d;
    end
  end

  // ********************************
  // FIFOs shared by data port and DMA
  // ********************************
  logic tx_push, tx_pop, tx_full, tx_empty;
  logic [7:0] tx_in, tx_head;
  logic rx_push, rx_pop, rx_full, rx_empty;
  asp_rx_char_t rx_in, rx_head;
  logic [CW-1:0] rx_cnt;

  assign tx_push = data_wr_i || dma_tx_wr_i; // [RQ9] [RQ10]
  assign tx_in = data_wr_i ? data_wdata_i : dma_tx_wdata_i;
  assign rx_pop = data_rd_i || dma_rx_rd_i; // [RQ9] [RQ10]

  asp_fifo #(.W(8), .DEPTH(DEPTH)) u_txf (
    .clk_i(clk_i), .nrst_i(nrst_i), .flush_i(!uart_en),
    .push_i(tx_push), .data_i(tx_in), .pop_i(tx_pop),
    .data_o(tx_head), .count_o(), .full_o(tx_full),
    .empty_o(tx_empty)
  );

  asp_fifo #(.W(10), .DEPTH(DEPTH)) u_rxf (
    .clk_i(clk_i), .nrst_i(nrst_i), .flush_i(!uart_en),
    .push_i(rx_push), .data_i(rx_in), .pop_i(rx_pop),
    .data_o(rx_head), .count_o(rx_cnt), .full_o(rx_full),
    .empty_o(rx_empty)
  );

  // ********************************
  // Transmitter
  // ********************************
  asp_tx_st_t tx_st_q, tx_st_d;
  logic [7:0] tx_sh_q, tx_sh_d;
  logic [2:0] tx_bit_q, tx_bit_d, last_bit;
  logic tx_par_q, tx_par_d, txd_q, txd_d, tx_restart, tx_tick;

  assign last_bit = cfg.data_8bit ? 3'h7 : 3'h6;

  asp_baud #(.CNT_W(BW)) u_txb (
    .clk_i(clk_i), .nrst_i(nrst_i), .ref_tick_i(ref_tick),
    .restart_i(tx_restart), .divisor_i(divisor),
    .bit_tick_o(tx_tick), .mid_tick_o()
  );

  always_comb begin
    tx_st_d = tx_st_q;
    tx_sh_d = tx_sh_q;
    tx_bit_d = tx_bit_q;
    tx_par_d = tx_par_q;
    txd_d = txd_q;
    tx_pop = 1'b0;
    tx_restart = 1'b0;
    case (tx_st_q)
      TX_IDLE: begin
        txd_d = 1'b1; // [RQ8]
        if (uart_en && !tx_empty &&
            (!cfg.flow_control_enable || !ncts_i)) begin // [RQ11] [RQ14]
          tx_pop = 1'b1;
          tx_restart = 1'b1;
          tx_sh_d = tx_head;
          tx_par_d = asp_parity(tx_head, cfg.data_8bit,
                                cfg.odd_parity_select); // [RQ6]
          tx_bit_d = 3'h0;
          txd_d = 1'b0; // [RQ8]
          tx_st_d = TX_START;
        end
      end
      TX_START: begin
        if (tx_tick) begin
          txd_d = tx_sh_q[0]; // [RQ7]
          tx_st_d = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_tick) begin
          if (tx_bit_q == last_bit) begin
            if (cfg.parity_enable) begin // [RQ5]
              txd_d = tx_par_q;
              tx_st_d = TX_PAR;
            end else begin
              txd_d = 1'b1;
              tx_st_d = TX_STOP1;
            end
          end else begin
            tx_sh_d = tx_sh_q >> 1; // [RQ7]
            txd_d = tx_sh_q[1];
            tx_bit_d = tx_bit_q + 3'h1;
          end
        end
      end
      TX_PAR: begin
        if (tx_tick) begin
          txd_d = 1'b1;
          tx_st_d = TX_STOP1;
        end
      end
      TX_STOP1: begin
        if (tx_tick) begin
          tx_st_d = cfg.two_stop_select ? TX_STOP2 : TX_IDLE; // [RQ4]
        end
      end
      TX_STOP2: begin
        if (tx_tick) begin
          tx_st_d = TX_IDLE;
        end
      end
      default: begin
        tx_st_d = TX_IDLE;
        txd_d = 1'b1;
      end
    endcase
    if (!uart_en) begin
      tx_st_d = TX_IDLE;
      txd_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_st_q <= TX_IDLE;
      tx_sh_q <= '0;
      tx_bit_q <= '0;
      tx_par_q <= 1'b0;
      txd_q <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      tx_sh_q <= tx_sh_d;
      tx_bit_q <= tx_bit_d;
      tx_par_q <= tx_par_d;
      txd_q <= txd_d;
    end
  end

  // ********************************
  // Receiver
  // ********************************
  asp_rx_st_t rx_st_q, rx_st_d;
  logic [7:0] rx_sh_q, rx_sh_d, rx_data;
  logic [2:0] rx_bit_q, rx_bit_d;
  logic rx_perr_q, rx_perr_d, rx_restart, rx_mid, rx_done, rx_lost;

  assign rx_data = cfg.data_8bit ? rx_sh_q : {1'b0, rx_sh_q[7:1]};
  assign rx_done = (rx_st_q == RX_STOP) && rx_mid;
  assign rx_push = rx_done;
  assign rx_lost = rx_done && rx_full; // [RQ22]
  assign rx_in = '{frame_err: !rxd_i, parity_err: rx_perr_q,
                   data: rx_data};

  asp_baud #(.CNT_W(BW)) u_rxb (
    .clk_i(clk_i), .nrst_i(nrst_i), .ref_tick_i(ref_tick),
    .restart_i(rx_restart), .divisor_i(divisor),
    .bit_tick_o(), .mid_tick_o(rx_mid)
  );

  always_comb begin
    rx_st_d = rx_st_q;
    rx_sh_d = rx_sh_q;
    rx_bit_d = rx_bit_q;
    rx_perr_d = rx_perr_q;
    rx_restart = 1'b0;
    case (rx_st_q)
      RX_IDLE: begin
        rx_perr_d = 1'b0;
        if (uart_en && !rxd_i) begin // [RQ8]
          rx_restart = 1'b1;
          rx_st_d = RX_START;
        end
      end
      RX_START: begin
        if (ref_tick && rxd_i) begin
          rx_st_d = RX_IDLE; // [RQ24]
        end else if (rx_mid) begin
          rx_bit_d = 3'h0;
          rx_st_d = RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_mid) begin
          rx_sh_d = {rxd_i, rx_sh_q[7:1]}; // [RQ7]
          rx_bit_d = rx_bit_q + 3'h1;
          if (rx_bit_q == last_bit) begin
            rx_st_d = cfg.parity_enable ? RX_PAR : RX_STOP; // [RQ5]
          end
        end
      end
      RX_PAR: begin
        if (rx_mid) begin
          rx_perr_d = rxd_i != asp_parity(rx_data, cfg.data_8bit,
                                          cfg.odd_parity_select); // [RQ6]
          rx_st_d = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rx_mid) begin
          rx_st_d = RX_IDLE; // [RQ4]
        end
      end
      default: begin
        rx_st_d = RX_IDLE;
      end
    endcase
    if (!uart_en) begin
      rx_st_d = RX_IDLE;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_st_q <= RX_IDLE;
      rx_sh_q <= '0;
      rx_bit_q <= '0;
      rx_perr_q <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_sh_q <= rx_sh_d;
      rx_bit_q <= rx_bit_d;
      rx_perr_q <= rx_perr_d;
    end
  end

  // ********************************
  // Flow control, flags and events
  // ********************************
  logic nrts_d, room2;
  logic [2:0] fl_q, fl_d, evf_d;
  logic [1:0] txa_q, rxa_q;
  logic [2:0] everr_q, everr_d;
  logic [2:0] evf_q;
  logic [1:0] evtd_q, evrd_q;
  asp_rx_char_t rx_char_q;

  assign room2 = (CW'(DEPTH) - rx_cnt) >= CW'(RTS_MIN_FREE);

  always_comb begin
    if (!cfg.flow_control_enable) begin
      nrts_d = 1'b1; // [RQ14]
    end else if (cfg.auto_request_control) begin
      nrts_d = !room2; // [RQ12]
    end else begin
      nrts_d = !cfg.sw_request_to_send; // [RQ13]
    end
    fl_d = {tx_empty && (tx_st_q == TX_IDLE), !tx_full, !rx_empty};
    evf_d = event_edge_level_select_i ? fl_d
                                      : fl_d & ~fl_q; // [RQ18] [RQ19] [RQ20]
    everr_d = {rx_done && rx_perr_q, rx_done && !rxd_i,
               rx_lost}; // [RQ22] [RQ16]
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nrts_o <= 1'b1;
      fl_q <= 3'h6; // Idle levels, no false edge
      rx_char_q <= '0;
      evf_q <= '0;
      everr_q <= '0;
      txa_q <= '0;
      rxa_q <= '0;
      evtd_q <= '0;
      evrd_q <= '0;
    end else begin
      nrts_o <= nrts_d;
      rx_char_q <= rx_head;
      fl_q <= fl_d;
      evf_q <= evf_d;
      everr_q <= everr_d;
      txa_q <= tx_buffer_active_ab_i;
      rxa_q <= rx_buffer_active_ab_i;
      evtd_q <= txa_q & ~tx_buffer_active_ab_i; // [RQ21]
      evrd_q <= rxa_q & ~rx_buffer_active_ab_i; // [RQ21]
    end
  end

  // ********************************
  // Receive DMA error offsets
  // ********************************
  logic [OFF_W-1:0] off_q [2];
  logic [OFF_W-1:0] off_d [2];
  logic [1:0] vld_q, vld_d;

  always_comb begin
    off_d = off_q;
    vld_d = vld_q;
    for (int b = 0; b < 2; b++) begin
      if (rx_dma_reset_i ||
          (rx_buffer_load_ab_i[b] && !rx_buffer_active_ab_i[b])) begin
        vld_d[b] = 1'b0; // [RQ17]
      end
      if (!vld_q[b] && (rx_dma_buf_sel_i == b[0])) begin
        if (rx_lost) begin
          off_d[b] = rx_dma_count_i + OFF_W'(OVR_AHEAD); // [RQ16]
          vld_d[b] = 1'b1;
        end else if (dma_rx_rd_i && !rx_empty &&
                     (rx_head.parity_err || rx_head.frame_err)) begin
          off_d[b] = rx_dma_count_i; // [RQ15]
          vld_d[b] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      off_q[0] <= '0;
      off_q[1] <= '0;
      vld_q <= '0;
    end else begin
      off_q <= off_d;
      vld_q <= vld_d;
    end
  end

  // ********************************
  // Outputs
  // ********************************
  assign txd_o = txd_q;
  assign rx_char_o = rx_char_q;
  assign {tx_idle_flag_o, tx_space_flag_o, rx_valid_flag_o} = fl_q;
  assign {ev_tx_idle_o, ev_tx_space_o, ev_rx_valid_o} = evf_q;
  assign {ev_parity_err_o, ev_frame_err_o, rx_overrun_event_o} = everr_q;
  assign ev_tx_done_ab_o = evtd_q;
  assign ev_rx_done_ab_o = evrd_q;
  assign rx_error_offset_a_o = off_q[0];
  assign rx_error_offset_b_o = off_q[1];
  assign rx_error_valid_ab_o = vld_q;

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  AST_OFF_QUIET: assert property (!uart_en |=> txd_o) // [RQ1]
    else $error("line not idle while disabled");
  AST_IDLE_HIGH: assert property (tx_st_q == TX_IDLE |-> txd_o) // [RQ8]
    else $error("idle line low");
  AST_START_LOW: assert property ($rose(tx_st_q == TX_START)
    |-> !txd_o && $past(!tx_empty)) // [RQ8]
    else $error("start bit not low");
  AST_CTS_GATE: assert property (tx_st_q == TX_IDLE &&
    cfg.flow_control_enable && ncts_i |=> tx_st_q == TX_IDLE) // [RQ11]
    else $error("started while clear-to-send high");
  AST_ONE_STOP: assert property (tx_st_q == TX_STOP1 && tx_tick &&
    !cfg.two_stop_select |=> tx_st_q == TX_IDLE) // [RQ4]
    else $error("extra stop bit");
  AST_NO_PAR: assert property (tx_st_q == TX_DATA && tx_tick &&
    tx_bit_q == last_bit && !cfg.parity_enable
    |=> tx_st_q == TX_STOP1 && txd_o) // [RQ5]
    else $error("parity bit sent while disabled");
  AST_RTS_AUTO: assert property (cfg.flow_control_enable &&
    cfg.auto_request_control |=> nrts_o == !$past(room2)) // [RQ12]
    else $error("automatic request wrong");
  AST_RTS_SW: assert property (cfg.flow_control_enable &&
    !cfg.auto_request_control
    |=> nrts_o == !$past(cfg.sw_request_to_send)) // [RQ13]
    else $error("manual request wrong");
  AST_RTS_OFF: assert property (!cfg.flow_control_enable |=> nrts_o) // [RQ14]
    else $error("request driven without flow control");
  AST_OVR_EVT: assert property (rx_done && rx_full
    |=> rx_overrun_event_o) // [RQ22]
    else $error("overrun not flagged");
  AST_GLITCH: assert property (rx_st_q == RX_START && ref_tick &&
    rxd_i && uart_en |=> rx_st_q == RX_IDLE) // [RQ24]
    else $error("false start accepted");
  AST_BUF_DONE: assert property ($fell(tx_buffer_active_ab_i[0])
    |=> ev_tx_done_ab_o[0]) // [RQ21]
    else $error("buffer complete missed");

  COV_TX_FRAME: cover property (tx_st_q == TX_STOP2 ##1
    tx_st_q == TX_IDLE);
  COV_RX_CHAR: cover property (rx_done && !rx_full);
  COV_OVERRUN: cover property (rx_lost);
  COV_GLITCH: cover property (rx_st_q == RX_START ##1 rx_st_q == RX_IDLE);
endmodule
`default_nettype wire

//--- inc/asp_pkg.sv
package asp_pkg;

  // ********************************
  // Clocking and timing
  // ********************************
  localparam logic [7:0] CLK_MHZ = 8'h7d;
  localparam logic [7:0] REF_MHZ = 8'h18;

  // ********************************
  // Sizes and fixed counts
  // ********************************
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned RTS_MIN_FREE = 2;
  localparam int unsigned OVR_AHEAD = 4;
  localparam int unsigned DIVN_W = 16;
  localparam int unsigned DIVF_W = 1;
  localparam int unsigned OFF_W = 16;
  localparam int unsigned CTRL_ID_DEF = 1;

  // ********************************
  // Controller mode field
  // ********************************
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_UART = 2'h1;
  localparam logic [1:0] MODE_SPI = 2'h2;
  localparam logic [1:0] MODE_I2C = 2'h3;

  // ********************************
  // Carriers
  // ********************************
  typedef struct packed {
    logic sw_request_to_send;
    logic auto_request_control;
    logic flow_control_enable;
    logic data_8bit;
    logic odd_parity_select;
    logic parity_enable;
    logic two_stop_select;
  } asp_cfg_t;

  typedef struct packed {
    logic frame_err;
    logic parity_err;
    logic [7:0] data;
  } asp_rx_char_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_START = 3'h1,
    TX_DATA = 3'h2,
    TX_PAR = 3'h3,
    TX_STOP1 = 3'h4,
    TX_STOP2 = 3'h5
  } asp_tx_st_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h2,
    RX_PAR = 3'h3,
    RX_STOP = 3'h4
  } asp_rx_st_t;

  // Even parity is XOR of the data bits, odd its inverse
  function automatic logic asp_parity(input logic [7:0] d,
                                      input logic eight,
                                      input logic odd);
    logic x;
    x = (^d[6:0]) ^ (eight & d[7]);
    return x ^ odd;
  endfunction

endpackage

//--- rtl/asp_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module asp_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned DEPTH = 4,
  parameter int unsigned CW = $clog2(DEPTH + 1)
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic flush_i,
  input wire logic push_i,
  input wire logic [W-1:0] data_i,
  input wire logic pop_i,
  output logic [W-1:0] data_o,
  output logic [CW-1:0] count_o,
  output logic full_o,
  output logic empty_o
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("asp_fifo: depth must be a power of two of at least 2");
  end

  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [PW-1:0] rd_q, rd_d, wr_q, wr_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic do_push, do_pop;

  assign full_o = (cnt_q == CW'(DEPTH));
  assign empty_o = (cnt_q == '0);
  assign data_o = mem_q[rd_q];
  assign count_o = cnt_q;
  assign do_push = push_i && !full_o;
  assign do_pop = pop_i && !empty_o;

  always_comb begin
    mem_d = mem_q;
    rd_d = rd_q;
    wr_d = wr_q;
    cnt_d = cnt_q;
    if (flush_i) begin
      rd_d = '0;
      wr_d = '0;
      cnt_d = '0;
    end else begin
      if (do_push) begin
        mem_d[wr_q] = data_i;
        wr_d = wr_q + 1'b1;
      end
      if (do_pop) begin
        rd_d = rd_q + 1'b1;
      end
      cnt_d = cnt_q + CW'(do_push) - CW'(do_pop);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

//--- rtl/asp_baud.sv
`timescale 1ns/1ns
`default_nettype none
module asp_baud #(
  parameter int unsigned CNT_W = 17
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ref_tick_i,
  input wire logic restart_i,
  input wire logic [CNT_W-1:0] divisor_i,
  output logic bit_tick_o,
  output logic mid_tick_o
);
  if (CNT_W < 4) begin : g_chk
    $error("asp_baud: counter too narrow");
  end

  logic [CNT_W-1:0] cnt_q, cnt_d, last;

  assign last = divisor_i - 1'b1;
  assign bit_tick_o = ref_tick_i && !restart_i && (cnt_q == last);
  assign mid_tick_o = ref_tick_i && !restart_i &&
                      (cnt_q == (divisor_i >> 1));

  always_comb begin
    cnt_d = cnt_q;
    if (restart_i) begin
      cnt_d = '0;
    end else if (ref_tick_i) begin
      cnt_d = (cnt_q >= last) ? '0 : cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

//--- test/asp_peer.sv
`timescale 1ns/1ns
`default_nettype none
// ****************
// Far-end serial device
// ****************
module asp_peer #(
  parameter int BITC = 83
) (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  logic [10:0] cap;
  logic [10:0] cap_q[$];
  int nb = 10;

  initial line_o = 1'b1; // Idle high

  task automatic hold(input logic b);
    line_o <= b;
    repeat (BITC) @(posedge clk_i);
  endtask

  // Eight data bits; wrong parity or stop only on request
  task automatic send(input logic [7:0] d, input logic par, input logic odd,
                      input logic stop);
    @(posedge clk_i);
    hold(1'b0); // Low start bit
    for (int k = 0; k < 8; k++) begin
      hold(d[k]); // LSB first
    end
    if (par) begin
      hold(^d ^ odd);
    end
    hold(stop);
    hold(1'b1);
  endtask

  // Capture nb bits after start at mid-bit
  always begin
    @(negedge line_i);
    repeat (BITC / 2) @(posedge clk_i);
    if (line_i === 1'b0) begin
      cap = '0;
      for (int k = 0; k < nb; k++) begin
        repeat (BITC) @(posedge clk_i);
        cap[k] = line_i;
      end
      cap_q.push_back(cap);
    end
  end
endmodule
`default_nettype wire

//--- test/asp_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module asp_top_test;
  import asp_pkg::*;
  localparam int BITC = 83;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [1:0] mode = MODE_UART;
  asp_cfg_t cfg = '0;
  logic wr = 1'b0, dwr = 1'b0, rd = 1'b0, drd = 1'b0, dma_rst = 1'b0;
  logic ncts = 1'b1, evsel = 1'b0;
  logic [1:0] act = 2'h0, ld = 2'h0;
  logic [7:0] wd = 8'h00;
  logic txd, nrts, rxd, txi, txs, rxv, ev_ti, ev_ts, ev_rv, ev_pe, ev_fe, ovf;
  logic [1:0] ev_td, ev_rd, err_v;
  logic [15:0] off_a;
  asp_rx_char_t rxc;
  logic [6:0] seen = 7'h00;
  logic [2:0] fmt [4] = '{3'h7, 3'h4, 3'h3, 3'h5};
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;

  always #4 clk_i = ~clk_i;

  asp_top u_asp_top (.clk_i(clk_i), .nrst_i(nrst_i),
    .controller_mode_select_i(mode),
    .baud_integer_divisor_i(16'h0008),
    .baud_fraction_divisor_i(1'h0), .char_format_config_i(cfg),
    .event_edge_level_select_i(evsel), .data_wr_i(wr), .data_wdata_i(wd),
    .data_rd_i(rd), .dma_tx_wr_i(dwr), .dma_tx_wdata_i(wd),
    .dma_rx_rd_i(drd), .rx_dma_reset_i(dma_rst), .rx_dma_buf_sel_i(1'b0),
    .rx_dma_count_i(16'h0003), .rx_buffer_load_ab_i(ld),
    .tx_buffer_active_ab_i(act), .rx_buffer_active_ab_i(act),
    .rxd_i(rxd), .ncts_i(ncts), .txd_o(txd), .nrts_o(nrts),
    .rx_char_o(rxc), .tx_idle_flag_o(txi), .tx_space_flag_o(txs),
    .rx_valid_flag_o(rxv), .ev_tx_idle_o(ev_ti), .ev_tx_space_o(ev_ts),
    .ev_rx_valid_o(ev_rv), .ev_tx_done_ab_o(ev_td), .ev_rx_done_ab_o(ev_rd),
    .ev_parity_err_o(ev_pe), .ev_frame_err_o(ev_fe),
    .rx_overrun_event_o(ovf), .rx_error_offset_a_o(off_a),
    .rx_error_offset_b_o(), .rx_error_valid_ab_o(err_v));

  asp_peer #(.BITC(BITC)) u_asp_peer (.clk_i(clk_i), .line_i(txd),
    .line_o(rxd));

  // ****************
  // Event capture and timeout
  // ****************
  always @(posedge clk_i) begin
    seen <= seen | {ev_ts, ev_ti, ev_rv, |{ev_rd, ev_td}, ovf, ev_fe, ev_pe};
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      complete_run();
    end
  end

  // ****************
  // Access tasks
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic push(input logic [7:0] d, input logic dma);
    @(posedge clk_i);
    wd <= d;
    wr <= ~dma;
    dwr <= dma;
    @(posedge clk_i);
    wr <= 1'b0;
    dwr <= 1'b0;
  endtask

  task automatic pop(input logic dma);
    @(posedge clk_i);
    rd <= ~dma;
    drd <= dma;
    @(posedge clk_i);
    rd <= 1'b0;
    drd <= 1'b0;
  endtask

  task automatic gap(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic wait_cap(input int n);
    while (u_asp_peer.cap_q.size() < n) @(negedge clk_i);
  endtask

  task automatic wait_rxv;
    while (rxv !== 1'b1) @(negedge clk_i);
  endtask

  // Expected frame bits after start; f is {eight, odd, parity}
  function automatic logic [10:0] frame(input logic [7:0] d,
                                        input logic [2:0] f);
    logic [10:0] e;
    int n;
    n = f[2] ? 8 : 7;
    e = '0;
    for (int k = 0; k < n; k++) begin
      e[k] = d[k];
    end
    e[n] = (^(d & (f[2] ? 8'hff : 8'h7f)) ^ f[1]) & f[0];
    e[n + int'(f[0])] = 1'b1;
    return e;
  endfunction

  task automatic complete_run;
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************
  // Tests
  // ****************
  initial begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(negedge clk_i);
    chk(txd, 1'b1);
    chk(nrts, 1'b1);
    gap(4);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      {cfg.data_8bit, cfg.odd_parity_select, cfg.parity_enable} <= fmt[i];
      cfg.two_stop_select <= i[1];
      u_asp_peer.nb = 8 + int'(fmt[i][2]) + int'(fmt[i][0]);
      push(8'hb5, i[0]);
      wait_cap(i + 1);
      chk(u_asp_peer.cap_q[i], frame(8'hb5, fmt[i]));
      gap(BITC);
      chk(txi, !i[1]);
    end
    @(posedge clk_i);
    cfg.flow_control_enable <= 1'b1;
    cfg.sw_request_to_send <= 1'b1;
    gap(2);
    chk(nrts, 1'b0);
    repeat (4) push(8'h3c, 1'b0);
    gap(400);
    chk(16'(u_asp_peer.cap_q.size()), 16'h0004);
    chk(txs, 1'b0);
    @(posedge clk_i);
    ncts <= 1'b0;
    while (txd !== 1'b0) @(negedge clk_i);
    @(posedge clk_i);
    ncts <= 1'b1;
    wait_cap(5);
    chk(u_asp_peer.cap_q[4], frame(8'h3c, 3'h5));
    gap(400);
    chk(16'(u_asp_peer.cap_q.size()), 16'h0005);
    chk(seen[6], 1'b1);
    @(posedge clk_i);
    ncts <= 1'b0;
    wait_cap(8);
    gap(3 * BITC);
    chk(txi, 1'b1);
    chk(seen[5], 1'b1);
    @(posedge clk_i);
    cfg.auto_request_control <= 1'b1;
    gap(2);
    chk(nrts, 1'b0);
    u_asp_peer.send(8'h5a, 1'b1, 1'b0, 1'b1);
    wait_rxv();
    chk(rxc, {2'b00, 8'h5a});
    chk(seen[4], 1'b1);
    u_asp_peer.send(8'h5a, 1'b1, 1'b1, 1'b1);
    u_asp_peer.send(8'h96, 1'b1, 1'b0, 1'b0);
    gap(4);
    chk(nrts, 1'b1);
    pop(1'b0);
    gap(2);
    chk(rxc, {2'b01, 8'h5a});
    chk(seen[0], 1'b1);
    pop(1'b1);
    gap(2);
    chk(rxc, {2'b10, 8'h96});
    chk(seen[1], 1'b1);
    chk(err_v, 2'h1);
    chk(off_a, 16'h0003);
    pop(1'b0);
    gap(3);
    chk(nrts, 1'b0);
    @(posedge clk_i);
    dma_rst <= 1'b1;
    @(posedge clk_i);
    dma_rst <= 1'b0;
    cfg.flow_control_enable <= 1'b0;
    gap(2);
    chk(err_v, 2'h0);
    repeat (5) u_asp_peer.send(8'h11, 1'b1, 1'b0, 1'b1);
    gap(4);
    chk(seen[2], 1'b1);
    chk(off_a, 16'h0007);
    @(posedge clk_i);
    ld <= 2'h1;
    @(posedge clk_i);
    ld <= 2'h0;
    gap(2);
    chk(err_v, 2'h0);
    chk(nrts, 1'b1);
    repeat (4) pop(1'b0);
    gap(3);
    chk(rxv, 1'b0);
    @(posedge clk_i);
    act <= 2'h3;
    @(posedge clk_i);
    act <= 2'h0;
    evsel <= 1'b1;
    gap(4);
    chk(seen[3], 1'b1);
    chk(ev_ti, 1'b1);
    @(posedge clk_i);
    mode <= MODE_SPI;
    push(8'h77, 1'b0);
    gap(1000);
    chk(16'(u_asp_peer.cap_q.size()), 16'h0008);
    complete_run();
  end
endmodule
`default_nettype wire
